// file: logic/xxe_exec.sv
// exchange and xor instruction decode and execution unit
module xxe_exec (
	input  wire logic                core_clk,
	input  wire logic                reset,
	input  wire logic                ins_valid,
	input  wire xxe_pkg::xxe_ins_t   ins_bytes,
	output logic                     ins_ready,
	output logic                     ins_illegal,
	output logic                     ins_done,
	output logic [2:0]               ins_len,
	input  wire logic [7:0]          pointer_segment,
	output xxe_pkg::xxe_mem_s        mem_req,
	input  wire logic [15:0]         mem_rdata,
	output xxe_pkg::xxe_flags_s      flags,
	input  wire logic [2:0]          rf_dbg_idx,
	output logic [15:0]              rf_dbg_data
);
	import xxe_pkg::*;

	typedef struct packed {
		xxe_state_e  fsm;
		xxe_dec_s    dec;
		logic [2:0]  k;
		logic [7:0]  seg;
		logic [15:0] memd;
		xxe_rf_t     regs;
		xxe_flags_s  flg;
	} xxe_st_s;

	localparam xxe_st_s XXE_ST_RST = '{fsm: st_idle, dec: '0, k: 3'h0,
		seg: XXE_SEG_RST, memd: XXE_REG_RST,
		regs: {8{XXE_REG_RST}}, flg: '0};

	xxe_st_s st_r;
	xxe_st_s st_nxt;

	// byte registers pair into word registers, odd index is the high half
	function automatic logic [15:0] get_reg(xxe_rf_t rf, logic [3:0] idx,
		logic word);
		logic [15:0] w;
		w = rf[idx[3:1]];
		if (word)
			get_reg = rf[idx[2:0]];
		else
			get_reg = {8'h00, idx[0] ? w[15:8] : w[7:0]};
	endfunction

	function automatic xxe_rf_t put_reg(xxe_rf_t rf, logic [3:0] idx,
		logic word, logic [15:0] v);
		xxe_rf_t r;
		r = rf;
		if (word)
			r[idx[2:0]] = v;
		else if (idx[0])
			r[idx[3:1]][15:8] = v[7:0];
		else
			r[idx[3:1]][7:0] = v[7:0];
		put_reg = r;
	endfunction

	// full decode of one fetched instruction
	function automatic xxe_dec_s decode(xxe_ins_t b);
		xxe_dec_s d;
		logic [2:0] nd;
		logic       imm_ok;
		d = '0;
		nd = 3'h0;
		d.word = b[0][XXE_SZ_BIT];
		d.rfa = b[1][7:4];
		d.rfb = b[1][3:0];
		d.ptr = b[1][2:0];
		d.mem_dst = b[1][XXE_DIR_BIT];
		d.dir = {b[1][2:0], b[2]};
		imm_ok = (b[1][3:0] == XXE_IMM_SEL);
		unique case (b[0][7:4])
			XXE_OPG_XCH_RR:
				if (b[0][2:0] == XXE_M_XCH)
					d.form = f_xch_rr;
			XXE_OPG_XCH_DIR:
				if (b[0][2:0] == XXE_M_XCH && b[1][XXE_DIR_BIT])
					d.form = f_xch_dir;
			XXE_OPG_XOR:
				unique case (b[0][2:0])
					XXE_M_RR:    d.form = f_rr;
					XXE_M_IND:   d.form = f_ind;
					XXE_M_INC:   d.form = f_inc;
					XXE_M_OFF8:  d.form = f_off8;
					XXE_M_OFF16: d.form = f_off16;
					XXE_M_DIR:   d.form = f_dir;
					default:     d.form = f_none;
				endcase
			XXE_OPG_IMM:
				if (imm_ok)
					unique case (b[0][2:0])
						XXE_M_RR:    d.form = f_imm_r;
						XXE_M_IND:   d.form = f_imm_ind;
						XXE_M_INC:   d.form = f_imm_inc;
						XXE_M_OFF8:  d.form = f_imm_off8;
						XXE_M_OFF16: d.form = f_imm_off16;
						XXE_M_DIR:   d.form = f_imm_dir;
						default:     d.form = f_none;
					endcase
			default: d.form = f_none;
		endcase
		// immediate memory forms: pointer sits in the upper nibble, memory is dest
		if (d.form inside {f_imm_ind, f_imm_inc, f_imm_off8, f_imm_off16})
			d.ptr = b[1][6:4];
		if (d.form inside {f_imm_ind, f_imm_inc, f_imm_off8, f_imm_off16,
			f_imm_dir, f_xch_dir})
			d.mem_dst = 1'b1;
		if (d.form inside {f_imm_r, f_rr, f_xch_rr})
			d.mem_dst = 1'b0;
		if (d.form inside {f_imm_dir})
			d.dir = {b[1][6:4], b[2]};
		// displacement bytes follow byte two
		if (d.form inside {f_off8, f_imm_off8}) begin
			nd = 3'h1;
			d.disp = {{8{b[2][7]}}, b[2]};
		end else if (d.form inside {f_off16, f_imm_off16}) begin
			nd = 3'h2;
			d.disp = {b[2], b[3]};
		end else if (d.form inside {f_dir, f_imm_dir, f_xch_dir}) begin
			nd = 3'h1;
		end
		d.len = XXE_BASE_LEN + nd;
		if (d.form inside {f_imm_r, f_imm_ind, f_imm_inc, f_imm_off8,
			f_imm_off16, f_imm_dir}) begin
			// upper byte of a 16-bit immediate arrives first
			d.imm = d.word ? {b[2 + nd], b[3 + nd]}
				: {8'h00, b[2 + nd]};
			d.len = d.len + (d.word ? 3'h2 : 3'h1);
		end
		unique case (d.form)
			f_xch_rr:              d.clocks = XXE_CLK_XCH_RR;
			f_xch_dir:             d.clocks = XXE_CLK_XCH_DIR;
			f_rr:                  d.clocks = XXE_CLK_RR;
			f_imm_r:               d.clocks = XXE_CLK_IMM_R;
			f_ind, f_imm_ind:      d.clocks = XXE_CLK_IND;
			f_inc, f_imm_inc:      d.clocks = XXE_CLK_INC;
			f_off8, f_off16, f_imm_off8, f_imm_off16:
				d.clocks = XXE_CLK_OFF;
			f_dir, f_imm_dir:      d.clocks = XXE_CLK_DIR;
			default:               d.clocks = 3'h0;
		endcase
		decode = d;
	endfunction

	xxe_dec_s    dec_in;
	xxe_dec_s    dc;
	logic        accept;
	logic        busy;
	logic        last;
	logic        uses_mem;
	logic        is_imm;
	logic        is_xch;
	logic [15:0] rega;
	logic [15:0] regb;
	logic [15:0] op_a;
	logic [15:0] op_b;
	logic [15:0] res;
	logic [15:0] ea;
	logic [15:0] step;

	assign dec_in = decode(ins_bytes);
	assign dc = st_r.dec;
	assign busy = (st_r.fsm == st_busy);
	assign last = busy && (st_r.k == dc.clocks - 3'h1);
	assign ins_ready = !busy;
	assign accept = ins_valid && ins_ready && dec_in.form != f_none;
	// unknown encodings are refused at the port, not executed
	assign ins_illegal = ins_valid && ins_ready && dec_in.form == f_none;
	assign ins_done = last;
	assign ins_len = dc.len;
	assign flags = st_r.flg;
	assign rf_dbg_data = st_r.regs[rf_dbg_idx];
	assign is_xch = dc.form inside {f_xch_rr, f_xch_dir};
	assign is_imm = dc.form inside {f_imm_r, f_imm_ind, f_imm_inc,
		f_imm_off8, f_imm_off16, f_imm_dir};
	assign uses_mem = !(dc.form inside {f_none, f_rr, f_imm_r, f_xch_rr});
	assign step = dc.word ? 16'h0002 : 16'h0001;

	// operand routing, both operands carry the same size
	always_comb begin
		rega = get_reg(st_r.regs, dc.rfa, dc.word);
		regb = get_reg(st_r.regs, dc.rfb, dc.word);
		if (dc.form == f_rr) begin
			op_a = rega;
			op_b = regb;
		end else if (is_imm) begin
			op_a = (dc.form == f_imm_r) ? rega : st_r.memd;
			op_b = dc.imm;
		end else if (dc.mem_dst) begin
			op_a = st_r.memd;
			op_b = rega;
		end else begin
			op_a = rega;
			op_b = st_r.memd;
		end
		res = op_a ^ op_b;
		if (!dc.word)
			res[15:8] = 8'h00;
		ea = st_r.regs[dc.ptr] + dc.disp;
	end

	// memory port is driven from registered state only
	always_comb begin
		mem_req.rd = busy && uses_mem && st_r.k == XXE_STEP_READ;
		mem_req.wr = last && uses_mem && dc.mem_dst;
		mem_req.word = dc.word;
		mem_req.direct = dc.form inside {f_dir, f_imm_dir, f_xch_dir};
		mem_req.addr = mem_req.direct ? {13'h0000, dc.dir}
			: {st_r.seg, ea};
		mem_req.wdata = is_xch ? rega : res;
	end

	// next state: accept, step, capture read data, retire
	always_comb begin
		st_nxt = st_r;
		unique case (st_r.fsm)
			st_idle:
				if (accept) begin
					st_nxt.fsm = st_busy;
					st_nxt.dec = dec_in;
					st_nxt.k = 3'h1;
					st_nxt.seg = pointer_segment;
				end
			st_busy: begin
				st_nxt.k = st_r.k + 3'h1;
				if (st_r.k == XXE_STEP_CAPT)
					st_nxt.memd = dc.word ? mem_rdata
						: {8'h00, mem_rdata[7:0]};
				if (last) begin
					st_nxt.fsm = st_idle;
					if (dc.form == f_xch_rr) begin
						st_nxt.regs = put_reg(st_nxt.regs, dc.rfa, dc.word,
							regb);
						st_nxt.regs = put_reg(st_nxt.regs, dc.rfb, dc.word,
							rega);
					end else if (dc.form == f_xch_dir) begin
						st_nxt.regs = put_reg(st_nxt.regs, dc.rfa, dc.word,
							st_r.memd);
					end else begin
						if (!dc.mem_dst)
							st_nxt.regs = put_reg(st_nxt.regs, dc.rfa,
								dc.word, res);
						st_nxt.flg.n = dc.word ? res[15] : res[7];
						st_nxt.flg.z = (res == 16'h0000);
					end
					// step after the data write
					if (dc.form inside {f_inc, f_imm_inc})
						st_nxt.regs[dc.ptr] = st_r.regs[dc.ptr] + step;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			st_r <= XXE_ST_RST;
		else
			st_r <= st_nxt;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	AST_XCH_RR: assert property (accept &&
		dec_in.form == f_xch_rr |-> ##4 (ins_done && ins_len == 3'h2))
		else $error("register exchange timing or length wrong");
	AST_XCH_SWAP: assert property (ins_done &&
		dc.form == f_xch_rr |=>
		get_reg(st_r.regs, $past(dc.rfa), $past(dc.word)) == $past(regb) &&
		get_reg(st_r.regs, $past(dc.rfb), $past(dc.word)) == $past(rega))
		else $error("register exchange did not swap");
	AST_XCH_DIR: assert property (accept &&
		dec_in.form == f_xch_dir |-> ##5 (ins_done && mem_req.wr &&
		ins_len == 3'h3)) else $error("direct exchange timing wrong");
	AST_FLAGS_HOLD: assert property (ins_done && is_xch |=>
		$stable(flags)) else $error("exchange changed flags");
	AST_RR_XOR: assert property (accept &&
		dec_in.form == f_rr |-> ##2 (ins_done && ins_len == 3'h2))
		else $error("register xor timing wrong");
	AST_IND: assert property (accept && dec_in.form == f_ind |->
		##1 mem_req.rd ##2 ins_done)
		else $error("pointer xor timing wrong");
	AST_OFF: assert property (accept &&
		dec_in.form inside {f_off8, f_off16, f_imm_off8, f_imm_off16} |->
		##5 ins_done) else $error("offset form timing wrong");
	AST_INC_STEP: assert property (ins_done &&
		dc.form inside {f_inc, f_imm_inc} |=> st_r.regs[$past(dc.ptr)] ==
		$past(st_r.regs[dc.ptr]) + $past(step))
		else $error("pointer auto increment wrong");
	AST_DIR_ADDR: assert property (mem_req.rd &&
		mem_req.direct |-> mem_req.addr[10:0] == dc.dir &&
		mem_req.addr[23:11] == 13'h0000) else $error("direct address wrong");
	AST_NZ: assert property (ins_done && !is_xch |=>
		flags.z == ($past(res) == 16'h0000) &&
		flags.n == ($past(dc.word) ? $past(res[15]) : $past(res[7])))
		else $error("sign or zero flag wrong");
	AST_SRC_KEEP: assert property (ins_done && dc.form == f_rr &&
		(dc.word ? dc.rfa[2:0] != dc.rfb[2:0] : dc.rfa != dc.rfb) |=>
		get_reg(st_r.regs, $past(dc.rfb), $past(dc.word)) == $past(regb))
		else $error("xor source modified");

	COV_XCH_DIR: cover property (ins_done && dc.form == f_xch_dir);
	COV_MEM_DST: cover property (mem_req.wr && dc.form == f_ind);
	COV_IMM16_INC: cover property (ins_done && dc.form == f_imm_inc &&
		dc.word);
endmodule

// file: logic/xxe_pkg.sv
// shared constants and carrier types for the exchange and xor executor
package xxe_pkg;

	// opcode groups in the upper nibble of byte one, then the immediate selector for the low nibble of byte two
	localparam logic [3:0] XXE_OPG_XCH_RR  = 4'h6;
	localparam logic [3:0] XXE_OPG_XCH_DIR = 4'ha;
	localparam logic [3:0] XXE_OPG_XOR     = 4'h7;
	localparam logic [3:0] XXE_OPG_IMM     = 4'h9;
	localparam logic [3:0] XXE_IMM_SEL     = 4'h7;

	// bit positions inside bytes one and two
	localparam int XXE_SZ_BIT  = 3;
	localparam int XXE_DIR_BIT = 3;

	// addressing mode codes in bits 2..0 of byte one
	localparam logic [2:0] XXE_M_XCH   = 3'h0;
	localparam logic [2:0] XXE_M_RR    = 3'h1;
	localparam logic [2:0] XXE_M_IND   = 3'h2;
	localparam logic [2:0] XXE_M_INC   = 3'h3;
	localparam logic [2:0] XXE_M_OFF8  = 3'h4;
	localparam logic [2:0] XXE_M_OFF16 = 3'h5;
	localparam logic [2:0] XXE_M_DIR   = 3'h6;

	// clock counts per form, accept cycle included
	localparam logic [2:0] XXE_CLK_XCH_RR  = 3'h5;
	localparam logic [2:0] XXE_CLK_XCH_DIR = 3'h6;
	localparam logic [2:0] XXE_CLK_RR      = 3'h3;
	localparam logic [2:0] XXE_CLK_IND     = 3'h4;
	localparam logic [2:0] XXE_CLK_INC     = 3'h5;
	localparam logic [2:0] XXE_CLK_OFF     = 3'h6;
	localparam logic [2:0] XXE_CLK_DIR     = 3'h4;
	localparam logic [2:0] XXE_CLK_IMM_R   = 3'h3;

	// lengths and execution steps
	localparam logic [2:0] XXE_BASE_LEN  = 3'h2;
	localparam logic [2:0] XXE_STEP_READ = 3'h1;
	localparam logic [2:0] XXE_STEP_CAPT = 3'h2;
	localparam int         XXE_INS_BYTES = 6;

	// reset values
	localparam logic [15:0] XXE_REG_RST = 16'h0000;
	localparam logic [7:0]  XXE_SEG_RST = 8'h00;

	typedef enum logic [3:0] {
		f_none, f_xch_rr, f_xch_dir, f_rr, f_ind, f_inc, f_off8, f_off16,
		f_dir, f_imm_r, f_imm_ind, f_imm_inc, f_imm_off8, f_imm_off16,
		f_imm_dir
	} xxe_form_e;

	typedef enum logic {st_idle, st_busy} xxe_state_e;

	typedef logic [XXE_INS_BYTES-1:0][7:0] xxe_ins_t;
	typedef logic [7:0][15:0]              xxe_rf_t;

	typedef struct packed {
		xxe_form_e   form;
		logic        word;
		logic        mem_dst;
		logic [3:0]  rfa;
		logic [3:0]  rfb;
		logic [2:0]  ptr;
		logic [15:0] disp;
		logic [15:0] imm;
		logic [10:0] dir;
		logic [2:0]  len;
		logic [2:0]  clocks;
	} xxe_dec_s;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        word;
		logic        direct;
		logic [23:0] addr;
		logic [15:0] wdata;
	} xxe_mem_s;

	typedef struct packed {
		logic n;
		logic z;
	} xxe_flags_s;

endpackage

// file: test/xxe_mem_model.sv
// data memory partner with a fixed one-cycle read latency
module xxe_mem_model (
	input  wire logic              core_clk,
	input  wire xxe_pkg::xxe_mem_s mem_req,
	output logic [15:0]            mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import xxe_pkg::*;
	logic [15:0] mem_r [logic [23:0]];
	logic [15:0] data_r = 16'h0000;
	logic        vld_r  = 1'b0;

	// words never written hold an address pattern
	function automatic logic [15:0] rdm(input logic [23:0] a);
		return mem_r.exists(a) ? mem_r[a] : a[15:0] ^ 16'hc3a5;
	endfunction

	// answer one cycle after the read; byte writes keep the high byte
	always @(posedge core_clk) begin
		logic [15:0] o;
		o = 16'h0000;
		if (mem_req.rd || mem_req.wr)
			o = rdm(mem_req.addr);
		vld_r <= mem_req.rd;
		if (mem_req.rd)
			data_r <= o;
		if (mem_req.wr)
			mem_r[mem_req.addr] = mem_req.word ? mem_req.wdata
				: {o[15:8], mem_req.wdata[7:0]};
	end

	// outside the answer cycle show junk so stale data is never trusted
	assign mem_rdata = vld_r ? data_r : ~data_r;
endmodule

// file: test/tb.sv
// self-checking bench for the exchange and xor executor
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import xxe_pkg::*;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        ins_valid = 1'b0;
	xxe_ins_t    ins_bytes = '0;
	logic        ins_ready, ins_illegal, ins_done;
	logic [2:0]  ins_len;
	logic [7:0]  pointer_segment = 8'h00;
	logic [7:0]  seg = 8'h00;
	xxe_mem_s    mem_req;
	logic [15:0] mem_rdata, rf_dbg_data, d;
	xxe_flags_s  flags, ef = '0;
	logic [2:0]  rf_dbg_idx = 3'h0, p;
	logic [3:0]  r;
	int          fails = 0, compares = 0, cnt = 0;
	int          seed = 32'h6f3c3f58;
	logic [15:0] rf [8] = '{default: 16'h0000};
	logic [15:0] tm [logic [23:0]];
	logic [5:0]  dq [$];
	logic [41:0] rq [$], wq [$];
	xxe_ins_t    bad [2] = '{48'h0000_0000_1250, 48'h0000_0000_1399};

	xxe_exec dut_u (.core_clk(core_clk), .reset(reset),
		.ins_valid(ins_valid), .ins_bytes(ins_bytes),
		.ins_ready(ins_ready), .ins_illegal(ins_illegal),
		.ins_done(ins_done), .ins_len(ins_len),
		.pointer_segment(pointer_segment), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .flags(flags),
		.rf_dbg_idx(rf_dbg_idx), .rf_dbg_data(rf_dbg_data));
	xxe_mem_model mm_u (.core_clk(core_clk), .mem_req(mem_req),
		.mem_rdata(mem_rdata));

	always #2.5 core_clk = ~core_clk;

	task automatic check(input logic [41:0] s, input logic [41:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function automatic logic [15:0] tr(input logic [23:0] a);
		return tm.exists(a) ? tm[a] : a[15:0] ^ 16'hc3a5;
	endfunction

	// byte register n lives in word n>>1, odd index in the high half
	function automatic logic [15:0] gr(input logic w, input logic [3:0] i);
		if (w)
			return rf[i[2:0]];
		return {8'h00, i[0] ? rf[i[3:1]][15:8] : rf[i[3:1]][7:0]};
	endfunction

	task automatic sr(input logic w, input logic [3:0] i,
		input logic [15:0] v);
		if (w)
			rf[i[2:0]] = v;
		else if (i[0])
			rf[i[3:1]][15:8] = v[7:0];
		else
			rf[i[3:1]][7:0] = v[7:0];
	endtask

	task automatic fl(input logic w, input logic [15:0] v);
		ef.n = w ? v[15] : v[7];
		ef.z = w ? v == 16'h0 : v[7:0] == 8'h0;
	endtask

	// issue at a falling edge, return at the first idle falling edge
	task automatic run(input xxe_ins_t b, input logic [2:0] n, c);
		int k;
		ins_valid = 1'b1;
		ins_bytes = b;
		pointer_segment = seg;
		dq.push_back({n, c});
		#1;
		check({ins_illegal, ins_ready}, 2'b01);
		@(posedge core_clk);
		k = 0;
		do begin
			@(negedge core_clk);
			k++;
		end while (ins_ready !== 1'b1 && k < 20);
		if (k == 20) begin
			fails++;
			stop_test();
		end
	endtask

	// idle cycles are needed to scan the register file
	task automatic regs();
		ins_valid = 1'b0;
		for (int i = 0; i < 8; i++) begin
			rf_dbg_idx = 3'(i);
			#1;
			check(rf_dbg_data, rf[i]);
			@(negedge core_clk);
		end
		check(flags, ef);
	endtask

	task automatic xo(input logic w, i, input logic [2:0] m,
		input logic md, input logic [3:0] r, input logic [2:0] p,
		input logic [15:0] d, iv);
		xxe_ins_t b;
		logic [15:0] o, v, x;
		logic [23:0] a;
		int k;
		seg = 8'($random(seed));
		b = '0;
		b[0] = {i ? 4'h9 : 4'h7, w, m};
		if (m == 3'h1)
			b[1] = {r, i ? 4'h7 : d[3:0]};
		else if (i)
			b[1] = {1'b0, m == 3'h6 ? d[10:8] : p, 4'h7};
		else
			b[1] = {r, md, m == 3'h6 ? d[10:8] : p};
		k = 2;
		if (m == 3'h5) begin
			b[2] = d[15:8];
			b[3] = d[7:0];
			k = 4;
		end else if (m >= 3'h4) begin
			b[2] = d[7:0];
			k = 3;
		end
		if (i) begin
			b[k] = w ? iv[15:8] : iv[7:0];
			b[k + 1] = w ? iv[7:0] : 8'h00;
			k += w ? 2 : 1;
		end
		x = i ? (w ? iv : {8'h00, iv[7:0]}) : gr(w, m == 3'h1 ? d[3:0] : r);
		if (m == 3'h1) begin
			v = gr(w, r) ^ x;
			sr(w, r, v);
		end else begin
			a = m == 3'h6 ? {13'h0, d[10:0]}
				: {seg, rf[p] + (m >= 3'h4 ? d : 16'h0)};
			o = tr(a);
			v = (w ? o : {8'h00, o[7:0]}) ^ x;
			rq.push_back({m == 3'h6, w, a, 16'h0});
			if (i || md) begin
				wq.push_back({m == 3'h6, w, a, v});
				tm[a] = w ? v : {o[15:8], v[7:0]};
			end else
				sr(w, r, v);
			if (m == 3'h3)
				rf[p] += w ? 16'h2 : 16'h1;
		end
		fl(w, v);
		run(b, 3'(k), m == 3'h1 ? 3'h3 : m == 3'h2 ? 3'h4 : m == 3'h3 ? 3'h5
			: m == 3'h6 ? 3'h4 : 3'h6);
	endtask

	task automatic xc(input logic w, dm, input logic [3:0] r,
		input logic [10:0] d);
		xxe_ins_t b;
		logic [15:0] o, v;
		logic [23:0] a;
		b = '0;
		b[0] = {dm ? 4'ha : 4'h6, w, 3'h0};
		b[1] = dm ? {r, 1'b1, d[10:8]} : {r, d[3:0]};
		b[2] = dm ? d[7:0] : 8'h00;
		v = gr(w, r);
		if (dm) begin
			a = {13'h0, d};
			o = tr(a);
			rq.push_back({1'b1, w, a, 16'h0});
			wq.push_back({1'b1, w, a, v});
			tm[a] = w ? v : {o[15:8], v[7:0]};
			sr(w, r, w ? o : {8'h00, o[7:0]});
		end else begin
			sr(w, r, gr(w, d[3:0]));
			sr(w, d[3:0], v);
		end
		run(b, dm ? 3'h3 : 3'h2, dm ? 3'h6 : 3'h5);
	endtask

	// completions and memory requests are matched to the oldest note
	always @(posedge core_clk) begin
		if (ins_valid && ins_ready && !ins_illegal)
			cnt = 0;
		else
			cnt++;
		if (ins_done)
			check({ins_len, 3'(cnt + 1)},
				dq.size() ? dq.pop_front() : 6'h3f);
		if (mem_req.rd)
			check({mem_req.direct, mem_req.word, mem_req.addr, 16'h0},
				rq.size() ? rq.pop_front() : '1);
		if (mem_req.wr)
			check({mem_req.direct, mem_req.word, mem_req.addr,
				mem_req.word ? mem_req.wdata : {8'h00, mem_req.wdata[7:0]}},
				wq.size() ? wq.pop_front() : '1);
	end

	initial begin
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		regs();
		for (int k = 0; k < 8; k++)
			xo(1'b1, 1'b1, 3'h1, 1'b0, 4'(k), 3'h0, 16'h0, 16'($random(seed)));
		xo(1'b0, 1'b1, 3'h1, 1'b0, 4'h7, 3'h0, 16'h0, 16'h00a5);
		regs();
		xo(1'b1, 1'b0, 3'h1, 1'b0, 4'h2, 3'h0, 16'h5, 16'h0);
		xo(1'b0, 1'b0, 3'h1, 1'b0, 4'h9, 3'h0, 16'h4, 16'h0);
		xo(1'b1, 1'b0, 3'h1, 1'b0, 4'h4, 3'h0, 16'h4, 16'h0);
		regs();
		// pointer never overlaps the register operand: that pairing is illegal
		for (int m = 2; m < 7; m++) begin
			for (int q = 0; q < 8; q++) begin
				p = 3'($random(seed));
				d = 16'($random(seed));
				if (m == 4)
					d = {{8{d[7]}}, d[7:0]};
				if (m < 4)
					d = 16'h0;
				if (m == 6)
					d[15:11] = 5'h0;
				r = q[0] ? {1'b0, p + 3'h1} : {p + 3'h1, d[0]};
				xo(q[0], q[2], 3'(m), q[1], r, p, d, 16'($random(seed)));
			end
			regs();
		end
		for (int q = 0; q < 4; q++) begin
			r = 4'($random(seed));
			xc(q[0], q[1], r, q[1] ? 11'($random(seed)) : {7'h0, r + 4'h1});
		end
		regs();
		foreach (bad[j]) begin
			ins_valid = 1'b1;
			ins_bytes = bad[j];
			#1;
			check({ins_illegal, ins_ready}, 2'b11);
			@(negedge core_clk);
		end
		ins_valid = 1'b0;
		regs();
		// a second reset in mid-run must clear registers and flags
		reset = 1'b1;
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		rf = '{default: 16'h0000};
		ef = '0;
		regs();
		xo(1'b1, 1'b1, 3'h1, 1'b0, 4'h1, 3'h0, 16'h0, 16'h8001);
		regs();
		// every noted completion and memory access must have appeared
		check(dq.size() + rq.size() + wq.size(), 0);
		stop_test();
	end
endmodule
